// ---- src/link_rx_pkg.sv ----
// Package: register map, field positions and reset values for the receive event status block
package link_rx_pkg;

  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] STATUS_OFFSET   = 8'h00;  // Read-clear event status
  localparam logic [7:0] IRQ_EN_OFFSET   = 8'h04;  // Interrupt enable
  localparam logic [7:0] IRQ_CLR_OFFSET  = 8'h08;  // Write-one-to-clear
  localparam logic [7:0] LINK_CTRL_OFFSET = 8'h0c; // Receiver enable, buffer size

  // ------------------------------------------------------------
  // Status and enable fields
  // ------------------------------------------------------------
  localparam int FLAG_BIT  = 0;  // Idle flag seen
  localparam int ABORT_BIT = 1;  // Abort sequence
  localparam int FCS_BIT   = 2;  // Frame check failure
  localparam int EOM_BIT   = 3;  // End of message or buffer full

  localparam logic [3:0] STATUS_RESET  = 4'h0;
  localparam logic [3:0] IRQ_EN_RESET  = 4'h0;
  localparam logic [7:0] FLAG_OCTET    = 8'h7e;
  localparam int         ABORT_ONES    = 7;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [15:0] CRC_GOOD     = 16'hf0b8;
  localparam logic [7:0] BUF_LIMIT_RESET = 8'h40;  // Octets before buffer-full
  localparam logic       RX_EN_RESET   = 1'b1;

endpackage : link_rx_pkg

// ---- src/hdlc_rx_event_status.sv ----
// Receive HDLC event detector with read-clear status register on APB
`timescale 1ns/1ps
`default_nettype none

module hdlc_rx_event_status
(
  input  wire logic        pclk,        // 10 MHz clock
  input  wire logic        presetn,     // Async reset, active low
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB access phase
  input  wire logic        pwrite,      // APB direction
  input  wire logic [7:0]  paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic      [31:0] prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error, unmapped address
  input  wire logic        link_bit,    // Incoming data link bit
  input  wire logic        link_bit_en, // Bit strobe, one cycle
  output logic             irq          // Level interrupt
);

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic       acc_setup;
  logic       rd_status;
  logic       addr_ok;
  assign acc_setup = psel && !penable;
  assign addr_ok   = (paddr == link_rx_pkg::STATUS_OFFSET) || (paddr == link_rx_pkg::IRQ_EN_OFFSET) ||
                     (paddr == link_rx_pkg::IRQ_CLR_OFFSET) || (paddr == link_rx_pkg::LINK_CTRL_OFFSET);
  // Read takes effect on the access edge
  assign rd_status = psel && penable && pready && !pwrite && (paddr == link_rx_pkg::STATUS_OFFSET);

  logic       wr_acc;
  assign wr_acc = psel && penable && pready && pwrite;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [3:0] irq_en_reg;
  logic       rx_en_reg;
  logic [7:0] buf_limit_reg;

  // Enable and control writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_en_reg    <= link_rx_pkg::IRQ_EN_RESET;
      rx_en_reg     <= link_rx_pkg::RX_EN_RESET;
      buf_limit_reg <= link_rx_pkg::BUF_LIMIT_RESET;
    end
    else if (wr_acc)
    begin
      if (paddr == link_rx_pkg::IRQ_EN_OFFSET)
        irq_en_reg <= pwdata[3:0];
      if (paddr == link_rx_pkg::LINK_CTRL_OFFSET)
      begin
        rx_en_reg     <= pwdata[0];
        buf_limit_reg <= pwdata[15:8];
      end
    end
  end

  // ------------------------------------------------------------
  // Bit destuffing, flag and abort detection
  // ------------------------------------------------------------
  logic [7:0] shift_reg;
  logic [2:0] ones_reg;
  logic       in_frame_reg;
  logic [2:0] bitcnt_reg;
  logic [7:0] octet_cnt_reg;
  logic [15:0] crc_reg;
  logic [7:0] shift_next;
  logic       flag_hit;
  logic       abort_hit;
  logic       stuffed;
  logic       bit_ok;

  assign bit_ok     = link_bit_en && rx_en_reg;
  assign shift_next = {link_bit, shift_reg[7:1]};  // LSB first
  assign flag_hit   = bit_ok && (shift_next == link_rx_pkg::FLAG_OCTET);
  assign abort_hit  = bit_ok && link_bit && (ones_reg == 3'(link_rx_pkg::ABORT_ONES - 1));
  assign stuffed    = !link_bit && (ones_reg == 3'd5);

  // Run of consecutive ones, saturating at seven
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ones_reg <= 3'd0;
    else if (bit_ok)
    begin
      if (!link_bit)
        ones_reg <= 3'd0;
      else if (ones_reg != 3'(link_rx_pkg::ABORT_ONES))
        ones_reg <= ones_reg + 3'd1;
    end
  end

  // Raw shift register for flag matching
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shift_reg <= 8'h00;
    else if (bit_ok)
      shift_reg <= shift_next;
  end

  // Frame state, octet count and FCS accumulation
  logic eom_hit;
  logic fcs_hit;
  logic buf_full_hit;
  logic data_bit;
  logic crc_fb;
  logic [15:0] crc_step;
  logic [15:0] crc_oct_reg;
  assign data_bit     = bit_ok && in_frame_reg && !stuffed && !flag_hit && !abort_hit;
  assign crc_fb       = crc_reg[0] ^ link_bit;
  assign crc_step     = (crc_reg >> 1) ^ (crc_fb ? link_rx_pkg::CRC_POLY_REV : 16'h0000);
  // Closing flag after at least one octet ends a message
  assign eom_hit      = flag_hit && in_frame_reg && (octet_cnt_reg != 8'h00);
  // Residue judged at the last octet edge: the closing flag's first seven bits must not count
  assign fcs_hit      = eom_hit && (crc_oct_reg != link_rx_pkg::CRC_GOOD);
  assign buf_full_hit = data_bit && (bitcnt_reg == 3'd7) &&
                        (octet_cnt_reg == buf_limit_reg - 8'h01);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_frame_reg  <= 1'b0;
      bitcnt_reg    <= 3'd0;
      octet_cnt_reg <= 8'h00;
      crc_reg       <= link_rx_pkg::CRC_INIT;
      crc_oct_reg   <= link_rx_pkg::CRC_INIT;
    end
    else if (flag_hit)
    begin
      in_frame_reg  <= 1'b1;
      bitcnt_reg    <= 3'd0;
      octet_cnt_reg <= 8'h00;
      crc_reg       <= link_rx_pkg::CRC_INIT;
      crc_oct_reg   <= link_rx_pkg::CRC_INIT;
    end
    else if (abort_hit || buf_full_hit)
    begin
      in_frame_reg  <= 1'b0;
      octet_cnt_reg <= 8'h00;
    end
    else if (data_bit)
    begin
      bitcnt_reg <= bitcnt_reg + 3'd1;
      crc_reg    <= crc_step;
      if (bitcnt_reg == 3'd7)
      begin
        octet_cnt_reg <= octet_cnt_reg + 8'h01;
        crc_oct_reg   <= crc_step;  // Snapshot at each octet edge
      end
    end
  end

  // ------------------------------------------------------------
  // Sticky status, read clears, set wins
  // ------------------------------------------------------------
  logic [3:0] status_reg;
  logic [3:0] status_next;
  logic [3:0] events;
  logic       clr_wr;
  assign clr_wr = wr_acc && (paddr == link_rx_pkg::IRQ_CLR_OFFSET);

  always_comb
  begin
    events = 4'h0;
    events[link_rx_pkg::EOM_BIT]   = eom_hit || buf_full_hit;
    events[link_rx_pkg::FCS_BIT]   = fcs_hit;
    events[link_rx_pkg::ABORT_BIT] = abort_hit;
    events[link_rx_pkg::FLAG_BIT]  = flag_hit;
    status_next = status_reg;
    // Clear only what the read returned, so a bit set at the setup edge survives
    if (rd_status)
      status_next = status_next & ~prdata[3:0];
    if (clr_wr)
      status_next = status_next & ~pwdata[3:0];
    status_next = status_next | events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_reg <= link_rx_pkg::STATUS_RESET;
    else
      status_reg <= status_next;
  end

  // Interrupt level from enabled sticky bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(status_next & irq_en_reg);
  end

  // ------------------------------------------------------------
  // APB response: no wait states, registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc_setup;
      pslverr <= acc_setup && !addr_ok;
      prdata  <= 32'h0000_0000;
      if (acc_setup && !pwrite)
      begin
        case (paddr)
          link_rx_pkg::STATUS_OFFSET:    prdata <= {28'h0, status_reg};
          link_rx_pkg::IRQ_EN_OFFSET:    prdata <= {28'h0, irq_en_reg};
          link_rx_pkg::LINK_CTRL_OFFSET: prdata <= {16'h0, buf_limit_reg, 7'h0, rx_en_reg};
          default:                       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_status_read;
    rd_status ##1 1'b1;
  endsequence

  AST_READ_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_status && !(|events)) |=> (({28'h0, status_reg} & $past(prdata)) == 32'h0000_0000))
    else $error("status not cleared by read");
  AST_EOM_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (eom_hit || buf_full_hit) |=> status_reg[link_rx_pkg::EOM_BIT])
    else $error("end of message not flagged");
  AST_FCS_SET: assert property (@(posedge pclk) disable iff (!presetn)
    fcs_hit |=> status_reg[link_rx_pkg::FCS_BIT])
    else $error("frame check failure not flagged");
  AST_ABORT_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (bit_ok && link_bit && ones_reg == 3'd6) |=> status_reg[link_rx_pkg::ABORT_BIT] && ones_reg == 3'd7)
    else $error("abort not flagged");
  AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (bit_ok && shift_next == 8'h7e) |=> status_reg[link_rx_pkg::FLAG_BIT] && in_frame_reg)
    else $error("flag octet not flagged");
  AST_IRQ_EOM: assert property (@(posedge pclk) disable iff (!presetn)
    (status_reg[link_rx_pkg::EOM_BIT] && irq_en_reg[link_rx_pkg::EOM_BIT] && !rd_status && !clr_wr) |=> irq)
    else $error("interrupt missing");
  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_read |-> $past(events) == (status_reg & $past(events)))
    else $error("event lost on clearing read");
  AST_NO_SPURIOUS: assert property (@(posedge pclk) disable iff (!presetn)
    (!status_reg[link_rx_pkg::ABORT_BIT] && !abort_hit) |=> !status_reg[link_rx_pkg::ABORT_BIT])
    else $error("abort bit set without cause");

endmodule : hdlc_rx_event_status

`default_nettype wire

// ---- sim/link_sender.sv ----
// Far-end link terminal model: sends flags, stuffed data octets and check words
`timescale 1ns/1ps
`default_nettype none

module link_sender
(
  input  wire logic pclk,        // Bench clock
  output logic      link_bit,    // Serial data, LSB first
  output logic      link_bit_en  // One-cycle strobe per bit
);
  logic [15:0] crc;
  int          ones;

  initial
  begin
    link_bit    = 1'b0;
    link_bit_en = 1'b0;
    crc         = 16'hffff;
    ones        = 0;
  end

  // One bit, then idle with the line inverted so stale data never looks valid
  task automatic put(input logic b);
    @(posedge pclk);
    link_bit    <= b;
    link_bit_en <= 1'b1;
    @(posedge pclk);
    link_bit    <= ~b;
    link_bit_en <= 1'b0;
  endtask : put

  // Unstuffed octet (flag or abort run); restarts the check word
  task automatic raw(input logic [7:0] d);
    for (int i = 0; i < 8; i++) put(d[i]);
    crc  = 16'hffff;
    ones = 0;
  endtask : raw

  // Data octet with a zero inserted after five ones
  task automatic data(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      put(d[i]);
      crc  = (crc >> 1) ^ ((crc[0] ^ d[i]) ? 16'h8408 : 16'h0000);
      ones = d[i] ? ones + 1 : 0;
      if (ones == 5)
      begin
        put(1'b0);
        ones = 0;
      end
    end
  endtask : data

  // Check word, low octet first; bad flips one bit
  task automatic fcs(input logic bad);
    logic [15:0] f;
    f = ~crc ^ {15'h0000, bad};
    data(f[7:0]);
    data(f[15:8]);
  endtask : fcs
endmodule : link_sender

`default_nettype wire

// ---- sim/hdlc_rx_event_status_tb_top.sv ----
// Testbench: APB register tests and link traffic for the receive event status block
`timescale 1ns/1ps
`default_nettype none

module hdlc_rx_event_status_tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        link_bit;
  logic        link_bit_en;
  logic        irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          compares;

  hdlc_rx_event_status u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_bit(link_bit), .link_bit_en(link_bit_en), .irq(irq));
  link_sender u_far (.pclk(pclk), .link_bit(link_bit), .link_bit_en(link_bit_en));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fails++;
      report_and_stop();
    end
  endtask : apb

  // Status read whose access edge (d 13) or setup edge (d 14) meets a flag's last bit
  task automatic aligned_read(input int d);
    fork
      u_far.raw(8'h7e);
      begin
        repeat (d) @(posedge pclk);
        apb(1'b0, link_rx_pkg::STATUS_OFFSET, 32'h0000_0000);
      end
    join
  endtask : aligned_read

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
  endtask : rd_chk

  task automatic frame(input logic bad);
    u_far.raw(8'h7e);
    u_far.data(8'ha5);
    u_far.data(8'h3c);
    u_far.fcs(bad);
    u_far.raw(8'h7e);
  endtask : frame

  // ------------------------------------------------------------
  // Clock, reset and test sequence
  // ------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; fails = 0; compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(link_rx_pkg::STATUS_OFFSET, 32'h0000_0000, "status reset");
    rd_chk(link_rx_pkg::LINK_CTRL_OFFSET, 32'h0000_4001, "ctrl reset");
    u_far.raw(8'h7e);
    rd_chk(link_rx_pkg::STATUS_OFFSET, 32'h0000_0001, "flag");
    rd_chk(link_rx_pkg::STATUS_OFFSET, 32'h0000_0000, "read clears");
    u_far.raw(8'hff);
    rd_chk(link_rx_pkg::STATUS_OFFSET, 32'h0000_0002, "abort");
    frame(1'b0);
    rd_chk(link_rx_pkg::STATUS_OFFSET, 32'h0000_0009, "good frame");
    frame(1'b1);
    rd_chk(link_rx_pkg::STATUS_OFFSET, 32'h0000_000d, "bad check");
    // Interrupt: masked, enabled, cleared, then cleared by read
    frame(1'b0);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000, "irq masked");
    apb(1'b1, link_rx_pkg::IRQ_EN_OFFSET, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001, "irq on");
    apb(1'b1, link_rx_pkg::IRQ_CLR_OFFSET, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    rd_chk(link_rx_pkg::IRQ_EN_OFFSET, 32'h0000_0008, "enable readback");
    frame(1'b0);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001, "irq again");
    rd_chk(link_rx_pkg::STATUS_OFFSET, 32'h0000_0009, "status");
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000, "irq after read");
    // Unmapped address answers with an error and zero data
    rd_chk(8'h10, 32'h0000_0000, "unmapped data");
    chk({31'h0, err}, 32'h0000_0001, "unmapped error");
    // Receiver off ignores bits; then a two-octet buffer fills
    apb(1'b1, link_rx_pkg::LINK_CTRL_OFFSET, 32'h0000_4000);
    u_far.raw(8'h7e);
    rd_chk(link_rx_pkg::STATUS_OFFSET, 32'h0000_0000, "rx off");
    apb(1'b1, link_rx_pkg::LINK_CTRL_OFFSET, 32'h0000_0201);
    u_far.raw(8'h7e);
    u_far.data(8'h11);
    u_far.data(8'h22);
    u_far.data(8'h33);
    rd_chk(link_rx_pkg::STATUS_OFFSET, 32'h0000_0009, "buffer full");
    // Event on the access or setup edge of a clearing read is kept
    aligned_read(13);
    chk(rd, 32'h0000_0000, "read at access edge");
    rd_chk(link_rx_pkg::STATUS_OFFSET, 32'h0000_0001, "kept at access edge");
    aligned_read(14);
    chk(rd, 32'h0000_0000, "read at setup edge");
    rd_chk(link_rx_pkg::STATUS_OFFSET, 32'h0000_0001, "kept at setup edge");
    // Mid-run reset returns status, enables and control to their reset values
    u_far.raw(8'h7e);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(link_rx_pkg::STATUS_OFFSET, 32'h0000_0000, "status after reset");
    rd_chk(link_rx_pkg::IRQ_EN_OFFSET, 32'h0000_0000, "enable after reset");
    rd_chk(link_rx_pkg::LINK_CTRL_OFFSET, 32'h0000_4001, "ctrl after reset");
    chk({31'h0, irq}, 32'h0000_0000, "irq after reset");
    report_and_stop();
  end
endmodule : hdlc_rx_event_status_tb_top

`default_nettype wire
